// ---- logic/regulator_pkg.sv ----
// Constants, register map and state codes for the regulator control slice.
// Assumes a 100 MHz system clock and a byte-wide register port.
package regulator_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_BUCK_B_LEVEL   = 8'h07;
    localparam logic [7:0] ADDR_LDO_A_CTRL     = 8'h08;
    localparam logic [7:0] ADDR_LDO_B_CTRL     = 8'h09;
    localparam logic [7:0] ADDR_LDO_A_LEVEL    = 8'h0a;
    localparam logic [7:0] ADDR_LDO_B_LEVEL    = 8'h0b;
    localparam logic [7:0] ADDR_BUCK_A_DELAYS  = 8'h0c;

    // Reset values
    localparam logic [7:0] RST_BUCK_B_LEVEL    = 8'hfc;
    localparam logic [7:0] RST_LDO_CTRL        = 8'h07;
    localparam logic [7:0] RST_LDO_LEVEL       = 8'h19;
    localparam logic [7:0] RST_BUCK_A_DELAYS   = 8'h00;
    localparam logic [7:0] READ_UNMAPPED       = 8'h00;

    // Field positions
    localparam int BIT_REG_ENABLE   = 0;
    localparam int BIT_PIN_SELECT   = 1;
    localparam int BIT_DISCHARGE    = 2;
    localparam int LDO_CODE_MSB     = 4;
    localparam int ON_DELAY_LSB     = 0;
    localparam int OFF_DELAY_LSB    = 4;
    localparam int DELAY_CODE_W     = 4;
    localparam int MV_W             = 12;

    // Second buck level code ranges and output levels in mV
    localparam logic [7:0] BUCK_RSV_LAST    = 8'h13;
    localparam logic [7:0] BUCK_FINE_FIRST  = 8'h14;
    localparam logic [7:0] BUCK_MID_FIRST   = 8'h18;
    localparam logic [7:0] BUCK_COARSE_FIRST = 8'h9e;
    localparam int BUCK_FINE_BASE_MV   = 700;
    localparam int BUCK_FINE_STEP_MV   = 10;
    localparam int BUCK_MID_BASE_MV    = 735;
    localparam int BUCK_MID_STEP_MV    = 5;
    localparam int BUCK_COARSE_BASE_MV = 1420;
    localparam int BUCK_COARSE_STEP_MV = 20;

    // Linear regulator level codes
    localparam logic [4:0] LDO_CODE_LAST = 5'h19;
    localparam int LDO_BASE_MV = 800;
    localparam int LDO_STEP_MV = 100;

    // Delay timing
    localparam int CLK_FREQ_KHZ      = 100000;
    localparam int DELAY_STEP_US     = 500;
    localparam int DELAY_STEP_CYCLES = DELAY_STEP_US * CLK_FREQ_KHZ / 1000;

    typedef enum logic [3:0] {
        SEQ_OFF      = 4'b0001,
        SEQ_WAIT_ON  = 4'b0010,
        SEQ_ON       = 4'b0100,
        SEQ_WAIT_OFF = 4'b1000
    } seq_state_t;

endpackage

// ---- logic/buck_on_sequencer.sv ----
// Start-up and shutdown delay sequencer for the first buck converter.
// Assumes the pin level input is already synchronised to clock_i.
module buck_on_sequencer #(
    parameter int STEP_CYCLES = regulator_pkg::DELAY_STEP_CYCLES
) (
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    input  wire logic       pin_level_i,
    input  wire logic [3:0] on_code_i,
    input  wire logic [3:0] off_code_i,
    input  wire logic       on_scale_i,
    input  wire logic       off_scale_i,
    output logic            run_o
);
    localparam int PRE_W = $clog2(STEP_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);
    localparam logic [PRE_W-1:0] PRE_ZERO = '0;
    localparam logic [4:0] STEPS_ZERO = 5'h00;
    localparam logic [4:0] STEPS_ONE  = 5'h01;

    regulator_pkg::seq_state_t state_reg, state_next;
    logic [PRE_W-1:0] pre_reg, pre_next;
    logic [4:0]       steps_reg, steps_next;
    logic             prev_reg, prev_next;
    logic             run_reg, run_next;
    logic [4:0]       on_len, off_len;
    logic             rise, fall, tick;

    assign run_o = run_reg;

    always_comb begin
        on_len  = on_scale_i ? {on_code_i, 1'b0} : {1'b0, on_code_i};
        off_len = off_scale_i ? {off_code_i, 1'b0} : {1'b0, off_code_i};
        rise = pin_level_i & ~prev_reg;
        fall = ~pin_level_i & prev_reg;
        tick = (pre_reg == PRE_LAST);
        state_next = state_reg;
        pre_next   = pre_reg;
        steps_next = steps_reg;
        prev_next  = pin_level_i;
        case (state_reg)
            regulator_pkg::SEQ_OFF: begin
                if (rise) begin
                    pre_next   = PRE_ZERO;
                    steps_next = on_len;
                    state_next = (on_len == STEPS_ZERO) ?
                        regulator_pkg::SEQ_ON :
                        regulator_pkg::SEQ_WAIT_ON;
                end
            end
            regulator_pkg::SEQ_WAIT_ON: begin
                if (fall) begin
                    state_next = regulator_pkg::SEQ_OFF;
                end else if (tick) begin
                    pre_next   = PRE_ZERO;
                    steps_next = steps_reg - STEPS_ONE;
                    if (steps_reg == STEPS_ONE) begin
                        state_next = regulator_pkg::SEQ_ON;
                    end
                end else begin
                    pre_next = pre_reg + PRE_W'(1);
                end
            end
            regulator_pkg::SEQ_ON: begin
                if (fall) begin
                    pre_next   = PRE_ZERO;
                    steps_next = off_len;
                    state_next = (off_len == STEPS_ZERO) ?
                        regulator_pkg::SEQ_OFF :
                        regulator_pkg::SEQ_WAIT_OFF;
                end
            end
            regulator_pkg::SEQ_WAIT_OFF: begin
                if (rise) begin
                    state_next = regulator_pkg::SEQ_ON;
                end else if (tick) begin
                    pre_next   = PRE_ZERO;
                    steps_next = steps_reg - STEPS_ONE;
                    if (steps_reg == STEPS_ONE) begin
                        state_next = regulator_pkg::SEQ_OFF;
                    end
                end else begin
                    pre_next = pre_reg + PRE_W'(1);
                end
            end
            default: begin
                state_next = regulator_pkg::SEQ_OFF;
            end
        endcase
        run_next = (state_next == regulator_pkg::SEQ_ON) ||
                   (state_next == regulator_pkg::SEQ_WAIT_OFF);
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= regulator_pkg::SEQ_OFF;
            pre_reg   <= '0;
            steps_reg <= 5'h00;
            prev_reg  <= 1'b0;
            run_reg   <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            pre_reg   <= pre_next;
            steps_reg <= steps_next;
            prev_reg  <= prev_next;
            run_reg   <= run_next;
        end
    end

endmodule // buck_on_sequencer

// ---- logic/regulator_control_regs.sv ----
// Register slice and enable logic for the second buck level, both linear
// regulators and the first buck start-up/shutdown delays.
// Assumes a serial engine on clock_i presents one byte write or read per
// strobe, and that the enable pin is asynchronous to clock_i.
//
// Summary of operation
// - Buck B codes 0x00-0x13 are flagged reserved; 0x14-0x17 give 700-730 mV.
// - Buck B codes 0x18-0x9d give 735-1400 mV in 5 mV steps.
// - Buck B codes 0x9e-0xff give 1420-3360 mV in 20 mV steps.
// - A disabled LDO discharges only when its discharge bit is set.
// - With pin select clear an LDO follows its register enable bit alone.
// - With pin select set an LDO runs only when enable bit and pin are high.
// - The LDO enable bit turns it off at 0 and on at 1; control resets to 0x07.
// - LDO codes give 800 mV plus 100 mV per step up to 0x19, reset 0x19.
// - Buck A turns off its shutdown code times 0.5 ms after a pin fall.
// - The shutdown scale input doubles the shutdown step to 1 ms.
// - Buck A turns on its start-up code times 0.5 ms after a pin rise.
// - The start-up scale input doubles the start-up step to 1 ms.
module regulator_control_regs #(
    parameter int HALF_MS_CYCLES = regulator_pkg::DELAY_STEP_CYCLES
) (
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    input  wire logic        ce_i,
    input  wire logic        enable_pin_i,
    input  wire logic        on_scale_i,
    input  wire logic        off_scale_i,
    input  wire logic        reg_write_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    output logic             ldo_a_on_o,
    output logic             ldo_b_on_o,
    output logic             ldo_a_discharge_o,
    output logic             ldo_b_discharge_o,
    output logic      [11:0] ldo_a_millivolts_o,
    output logic      [11:0] ldo_b_millivolts_o,
    output logic             ldo_a_code_reserved_o,
    output logic             ldo_b_code_reserved_o,
    output logic      [11:0] buck_b_millivolts_o,
    output logic             buck_b_code_reserved_o,
    output logic             buck_a_on_o
);
    localparam logic [11:0] MV_ZERO = 12'h000;

    // Register storage
    logic [7:0] buck_b_output_level_reg, buck_b_output_level_next;
    logic [7:0] buck_a_sequence_delays_reg, buck_a_sequence_delays_next;
    logic [7:0] ldo_control_reg [2];
    logic [7:0] ldo_control_next [2];
    logic [7:0] ldo_output_level_reg [2];
    logic [7:0] ldo_output_level_next [2];
    logic [7:0] rdata_reg, rdata_next;

    // Enable pin synchroniser and debounced level
    logic pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_level_reg;
    logic pin_level_next;

    // Decoded outputs
    logic [1:0]  ldo_on_reg, ldo_on_next;
    logic [1:0]  ldo_dis_reg, ldo_dis_next;
    logic [1:0]  ldo_rsv_reg, ldo_rsv_next;
    logic [11:0] ldo_mv_reg [2];
    logic [11:0] ldo_mv_next [2];
    logic [11:0] buck_mv_reg, buck_mv_next;
    logic        buck_rsv_reg, buck_rsv_next;

    logic [7:0] ldo_addr_ctrl [2];
    logic [7:0] ldo_addr_level [2];

    assign ldo_addr_ctrl[0]  = regulator_pkg::ADDR_LDO_A_CTRL;
    assign ldo_addr_ctrl[1]  = regulator_pkg::ADDR_LDO_B_CTRL;
    assign ldo_addr_level[0] = regulator_pkg::ADDR_LDO_A_LEVEL;
    assign ldo_addr_level[1] = regulator_pkg::ADDR_LDO_B_LEVEL;

    // Register writes and read data
    always_comb begin
        buck_b_output_level_next    = buck_b_output_level_reg;
        buck_a_sequence_delays_next = buck_a_sequence_delays_reg;
        for (int i = 0; i < 2; i++) begin
            ldo_control_next[i]      = ldo_control_reg[i];
            ldo_output_level_next[i] = ldo_output_level_reg[i];
        end
        if (reg_write_i) begin
            if (reg_addr_i == regulator_pkg::ADDR_BUCK_B_LEVEL) begin
                buck_b_output_level_next = reg_wdata_i;
            end
            if (reg_addr_i == regulator_pkg::ADDR_BUCK_A_DELAYS) begin
                buck_a_sequence_delays_next = reg_wdata_i;
            end
            for (int i = 0; i < 2; i++) begin
                if (reg_addr_i == ldo_addr_ctrl[i]) begin
                    ldo_control_next[i] = reg_wdata_i;
                end
                if (reg_addr_i == ldo_addr_level[i]) begin
                    ldo_output_level_next[i] = reg_wdata_i;
                end
            end
        end
        case (reg_addr_i)
            regulator_pkg::ADDR_BUCK_B_LEVEL: begin
                rdata_next = buck_b_output_level_reg;
            end
            regulator_pkg::ADDR_LDO_A_CTRL: begin
                rdata_next = ldo_control_reg[0];
            end
            regulator_pkg::ADDR_LDO_B_CTRL: begin
                rdata_next = ldo_control_reg[1];
            end
            regulator_pkg::ADDR_LDO_A_LEVEL: begin
                rdata_next = ldo_output_level_reg[0];
            end
            regulator_pkg::ADDR_LDO_B_LEVEL: begin
                rdata_next = ldo_output_level_reg[1];
            end
            regulator_pkg::ADDR_BUCK_A_DELAYS: begin
                rdata_next = buck_a_sequence_delays_reg;
            end
            default: begin
                rdata_next = regulator_pkg::READ_UNMAPPED;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            buck_b_output_level_reg    <= regulator_pkg::RST_BUCK_B_LEVEL;
            buck_a_sequence_delays_reg <= regulator_pkg::RST_BUCK_A_DELAYS;
            for (int i = 0; i < 2; i++) begin
                ldo_control_reg[i]      <= regulator_pkg::RST_LDO_CTRL;
                ldo_output_level_reg[i] <= regulator_pkg::RST_LDO_LEVEL;
            end
            rdata_reg <= regulator_pkg::READ_UNMAPPED;
        end else if (ce_i) begin
            buck_b_output_level_reg    <= buck_b_output_level_next;
            buck_a_sequence_delays_reg <= buck_a_sequence_delays_next;
            for (int i = 0; i < 2; i++) begin
                ldo_control_reg[i]      <= ldo_control_next[i];
                ldo_output_level_reg[i] <= ldo_output_level_next[i];
            end
            rdata_reg <= rdata_next;
        end
    end

    // Enable pin: a change counts once the second and third stages agree
    always_comb begin
        pin_level_next = (pin_s2_reg == pin_s3_reg) ? pin_s3_reg :
                         pin_level_reg;
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_s1_reg    <= 1'b0;
            pin_s2_reg    <= 1'b0;
            pin_s3_reg    <= 1'b0;
            pin_level_reg <= 1'b0;
        end else if (ce_i) begin
            pin_s1_reg    <= enable_pin_i;
            pin_s2_reg    <= pin_s1_reg;
            pin_s3_reg    <= pin_s2_reg;
            pin_level_reg <= pin_level_next;
        end
    end

    // Linear regulator enable, discharge and level decode
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            ldo_on_next[i] =
                ldo_control_reg[i][regulator_pkg::BIT_REG_ENABLE] &
                (~ldo_control_reg[i][regulator_pkg::BIT_PIN_SELECT] |
                 pin_level_reg);
            ldo_dis_next[i] = ~ldo_on_next[i] &
                ldo_control_reg[i][regulator_pkg::BIT_DISCHARGE];
            ldo_rsv_next[i] = (ldo_output_level_reg[i][7:0] >
                {3'b000, regulator_pkg::LDO_CODE_LAST});
            ldo_mv_next[i] = ldo_rsv_next[i] ? MV_ZERO :
                12'(regulator_pkg::LDO_BASE_MV + regulator_pkg::LDO_STEP_MV *
                int'(ldo_output_level_reg[i]
                     [regulator_pkg::LDO_CODE_MSB:0]));
        end
    end

    // Second buck level decode
    always_comb begin
        buck_rsv_next = 1'b0;
        if (buck_b_output_level_reg <= regulator_pkg::BUCK_RSV_LAST) begin
            buck_rsv_next = 1'b1;
            buck_mv_next  = MV_ZERO;
        end else if (buck_b_output_level_reg <
                     regulator_pkg::BUCK_MID_FIRST) begin
            buck_mv_next = 12'(regulator_pkg::BUCK_FINE_BASE_MV +
                regulator_pkg::BUCK_FINE_STEP_MV *
                int'(buck_b_output_level_reg -
                regulator_pkg::BUCK_FINE_FIRST));
        end else if (buck_b_output_level_reg <
                     regulator_pkg::BUCK_COARSE_FIRST) begin
            buck_mv_next = 12'(regulator_pkg::BUCK_MID_BASE_MV +
                regulator_pkg::BUCK_MID_STEP_MV *
                int'(buck_b_output_level_reg -
                regulator_pkg::BUCK_MID_FIRST));
        end else begin
            buck_mv_next = 12'(regulator_pkg::BUCK_COARSE_BASE_MV +
                regulator_pkg::BUCK_COARSE_STEP_MV *
                int'(buck_b_output_level_reg -
                regulator_pkg::BUCK_COARSE_FIRST));
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ldo_on_reg   <= 2'b00;
            ldo_dis_reg  <= 2'b00;
            ldo_rsv_reg  <= 2'b00;
            ldo_mv_reg[0] <= MV_ZERO;
            ldo_mv_reg[1] <= MV_ZERO;
            buck_mv_reg  <= MV_ZERO;
            buck_rsv_reg <= 1'b0;
        end else if (ce_i) begin
            ldo_on_reg   <= ldo_on_next;
            ldo_dis_reg  <= ldo_dis_next;
            ldo_rsv_reg  <= ldo_rsv_next;
            ldo_mv_reg[0] <= ldo_mv_next[0];
            ldo_mv_reg[1] <= ldo_mv_next[1];
            buck_mv_reg  <= buck_mv_next;
            buck_rsv_reg <= buck_rsv_next;
        end
    end

    // First buck delayed enable
    buck_on_sequencer #(
        .STEP_CYCLES (HALF_MS_CYCLES)
    ) u_buck_a_seq (
        .clock_i     (clock_i),
        .nrst_i      (nrst_i),
        .ce_i        (ce_i),
        .pin_level_i (pin_level_reg),
        .on_code_i   (buck_a_sequence_delays_reg[regulator_pkg::ON_DELAY_LSB +:
                      regulator_pkg::DELAY_CODE_W]),
        .off_code_i  (buck_a_sequence_delays_reg
                      [regulator_pkg::OFF_DELAY_LSB +:
                      regulator_pkg::DELAY_CODE_W]),
        .on_scale_i  (on_scale_i),
        .off_scale_i (off_scale_i),
        .run_o       (buck_a_on_o)
    );

    assign reg_rdata_o            = rdata_reg;
    assign ldo_a_on_o             = ldo_on_reg[0];
    assign ldo_b_on_o             = ldo_on_reg[1];
    assign ldo_a_discharge_o      = ldo_dis_reg[0];
    assign ldo_b_discharge_o      = ldo_dis_reg[1];
    assign ldo_a_millivolts_o     = ldo_mv_reg[0];
    assign ldo_b_millivolts_o     = ldo_mv_reg[1];
    assign ldo_a_code_reserved_o  = ldo_rsv_reg[0];
    assign ldo_b_code_reserved_o  = ldo_rsv_reg[1];
    assign buck_b_millivolts_o    = buck_mv_reg;
    assign buck_b_code_reserved_o = buck_rsv_reg;

endmodule // regulator_control_regs

// ---- tb/regulator_checker_assertions.sv ----
// Port checker for the regulator register slice.
// Assumes one clock domain with ce_i held high by the bench.
module regulator_checker #(
    parameter int HALF_MS_CYCLES = 8
) (
    input wire logic        clock_i,
    input wire logic        nrst_i,
    input wire logic        reg_write_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        ldo_a_on_o,
    input wire logic        ldo_b_on_o,
    input wire logic        ldo_a_discharge_o,
    input wire logic        ldo_b_discharge_o,
    input wire logic [11:0] ldo_a_millivolts_o,
    input wire logic [11:0] buck_b_millivolts_o,
    input wire logic        buck_b_code_reserved_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    // Expected buck B level in mV, zero for reserved codes
    function automatic logic [11:0] buck_mv(input logic [7:0] c);
        if (c < 8'h14) return 12'h000;
        if (c < 8'h18) return 12'(700 + 10 * (c - 8'h14));
        if (c < 8'h9e) return 12'(735 + 5 * (c - 8'h18));
        return 12'(1420 + 20 * (c - 8'h9e));
    endfunction

    AST_DISCHARGE_A: assert property (
        ldo_a_on_o |-> !ldo_a_discharge_o)
        else $error("ldo a discharges while running");
    AST_DISCHARGE_B: assert property (
        ldo_b_on_o |-> !ldo_b_discharge_o)
        else $error("ldo b discharges while running");
    AST_PIN_IGNORED: assert property (
        (reg_write_i && reg_addr_i == 8'h08 && reg_wdata_i[1:0] == 2'b01)
        ##1 !reg_write_i |=> ldo_a_on_o)
        else $error("ldo a not running on its enable bit alone");
    AST_REG_OFF: assert property (
        (reg_write_i && reg_addr_i == 8'h08 && !reg_wdata_i[0]) ##1
        !reg_write_i |=> !ldo_a_on_o &&
        ldo_a_discharge_o == $past(reg_wdata_i[2], 2))
        else $error("ldo a disable or discharge wrong after write");
    AST_LDO_LEVEL: assert property (
        (reg_write_i && reg_addr_i == 8'h0a && reg_wdata_i <= 8'h19) ##1
        !reg_write_i |=>
        ldo_a_millivolts_o == 12'(800 + 100 * $past(reg_wdata_i, 2)))
        else $error("ldo a level decode wrong");
    AST_BUCK_LEVEL: assert property (
        (reg_write_i && reg_addr_i == 8'h07) ##1 !reg_write_i |=>
        buck_b_millivolts_o == buck_mv($past(reg_wdata_i, 2)) &&
        buck_b_code_reserved_o == ($past(reg_wdata_i, 2) <= 8'h13))
        else $error("buck b level decode wrong");
    AST_READBACK: assert property (
        (reg_write_i && reg_addr_i >= 8'h07 && reg_addr_i <= 8'h0c) ##1
        $stable(reg_addr_i) ##1 $stable(reg_addr_i) |->
        reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("written byte not read back");
    AST_UNMAPPED: assert property (
        (reg_addr_i < 8'h07 || reg_addr_i > 8'h0c) |=> reg_rdata_o == 8'h00)
        else $error("unmapped address reads non zero");
endmodule // regulator_checker

bind regulator_control_regs regulator_checker #(
    .HALF_MS_CYCLES(HALF_MS_CYCLES)
) u_checker (
    .clock_i, .nrst_i, .reg_write_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .ldo_a_on_o, .ldo_b_on_o, .ldo_a_discharge_o,
    .ldo_b_discharge_o, .ldo_a_millivolts_o, .buck_b_millivolts_o,
    .buck_b_code_reserved_o
);

// ---- tb/host_model.sv ----
// Host side model: register port writes and reads, enable pin level.
// Assumes every task call starts just after a rising clock edge.
module host_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic            reg_write_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    output logic            enable_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_write_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        enable_pin_o = 1'b0;
    end

    // One write strobe, then a quiet edge; released data is inverted
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_write_o <= 1'b1;
        reg_addr_o <= a;
        reg_wdata_o <= d;
        @(posedge clock_i);
        reg_write_o <= 1'b0;
        reg_wdata_o <= ~d;
        @(posedge clock_i);
    endtask

    // Address held two edges so the registered read data is current
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr_o <= a;
        repeat (2) @(posedge clock_i);
        d = reg_rdata_i;
    endtask

    task automatic pin(input logic v);
        enable_pin_o <= v;
    endtask
endmodule // host_model

// ---- tb/test_regulator_control_regs.sv ----
// Self-checking bench for the regulator register slice.
// Assumes host_model and the bound checker are compiled before it.
module test_regulator_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int H = 8;
    localparam logic [7:0] RV [7] = '{8'hfc, 8'h07, 8'h07, 8'h19, 8'h19,
                                      8'h00, 8'h00};
    localparam logic [7:0] BC [8] = '{8'h00, 8'h13, 8'h14, 8'h17, 8'h18,
                                      8'h9d, 8'h9e, 8'hff};
    localparam logic [11:0] BM [8] = '{12'h000, 12'h000, 12'h2bc, 12'h2da,
                                       12'h2df, 12'h578, 12'h58c, 12'hd20};
    localparam logic [7:0] LC [5] = '{8'h00, 8'h0c, 8'h19, 8'h1a, 8'h20};

    logic        clock_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        on_scale_i = 1'b0;
    logic        off_scale_i = 1'b0;
    logic        reg_write_i, enable_pin_i, buck_a_on_o;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, d;
    logic        ldo_a_on_o, ldo_b_on_o, ldo_a_discharge_o, ldo_b_discharge_o;
    logic [11:0] ldo_a_millivolts_o, ldo_b_millivolts_o, buck_b_millivolts_o;
    logic        ldo_a_code_reserved_o, ldo_b_code_reserved_o;
    logic        buck_b_code_reserved_o;
    int          miscompares = 0;
    int          cmp_count = 0;

    always #5 clock_i = ~clock_i;

    regulator_control_regs #(.HALF_MS_CYCLES(H)) uut (
        .clock_i, .nrst_i, .ce_i(1'b1), .enable_pin_i, .on_scale_i,
        .off_scale_i, .reg_write_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
        .ldo_a_on_o, .ldo_b_on_o, .ldo_a_discharge_o, .ldo_b_discharge_o,
        .ldo_a_millivolts_o, .ldo_b_millivolts_o, .ldo_a_code_reserved_o,
        .ldo_b_code_reserved_o, .buck_b_millivolts_o,
        .buck_b_code_reserved_o, .buck_a_on_o);
    host_model host (
        .clock_i, .reg_rdata_i(reg_rdata_o), .reg_write_o(reg_write_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
        .enable_pin_o(enable_pin_i));

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge clock_i);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Pin edge, then buck A must hold before the delay and switch after it
    task automatic seq(input logic v, input logic [3:0] c, input logic s);
        int lo;
        lo = int'(c) * (s ? 2 : 1) * H;
        on_scale_i <= s & v;
        off_scale_i <= s & ~v;
        host.pin(v);
        repeat (lo + 2) @(posedge clock_i);
        check(12'(buck_a_on_o), 12'(!v));
        repeat (14) @(posedge clock_i);
        check(12'(buck_a_on_o), 12'(v));
    endtask

    initial begin
        logic [11:0] e;
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i);
        foreach (RV[i]) begin
            host.rd(8'h07 + 8'(i), d);
            check(12'(d), 12'(RV[i]));
        end
        check(12'(ldo_a_on_o), 12'h0);
        check(12'(ldo_a_discharge_o), 12'h1);
        check(ldo_a_millivolts_o, 12'hce4);
        $display("test reset done");
        host.pin(1'b1);
        repeat (10) @(posedge clock_i);
        check(12'(ldo_a_on_o), 12'h1);
        check(12'(ldo_b_on_o), 12'h1);
        check(12'(ldo_a_discharge_o), 12'h0);
        host.pin(1'b0);
        repeat (10) @(posedge clock_i);
        check(12'(ldo_b_on_o), 12'h0);
        check(12'(ldo_b_discharge_o), 12'h1);
        host.wr(8'h08, 8'h05);
        settle();
        check(12'(ldo_a_on_o), 12'h1);
        host.wr(8'h08, 8'h04);
        settle();
        check(12'(ldo_a_on_o), 12'h0);
        check(12'(ldo_a_discharge_o), 12'h1);
        host.wr(8'h08, 8'h00);
        settle();
        check(12'(ldo_a_discharge_o), 12'h0);
        host.rd(8'h09, d);
        check(12'(d), 12'h007);
        $display("test enable done");
        foreach (LC[i]) begin
            e = LC[i] > 8'h19 ? 12'h000 : 12'(800 + 100 * LC[i]);
            host.wr(8'h0a, LC[i]);
            host.wr(8'h0b, LC[i]);
            settle();
            check(ldo_a_millivolts_o, e);
            check(ldo_b_millivolts_o, e);
            check(12'(ldo_a_code_reserved_o), 12'(LC[i] > 8'h19));
            check(12'(ldo_b_code_reserved_o), 12'(LC[i] > 8'h19));
        end
        host.rd(8'h0a, d);
        check(12'(d), 12'h020);
        foreach (BC[i]) begin
            host.wr(8'h07, BC[i]);
            settle();
            check(buck_b_millivolts_o, BM[i]);
            check(12'(buck_b_code_reserved_o), 12'(i < 2));
        end
        $display("test levels done");
        host.wr(8'h0c, 8'h23);
        seq(1'b1, 4'h3, 1'b0);
        seq(1'b0, 4'h2, 1'b0);
        host.wr(8'h0c, 8'hff);
        seq(1'b1, 4'hf, 1'b1);
        seq(1'b0, 4'hf, 1'b1);
        host.wr(8'h0c, 8'h00);
        seq(1'b1, 4'h0, 1'b0);
        seq(1'b0, 4'h0, 1'b0);
        host.wr(8'h0c, 8'h04);
        host.pin(1'b1);
        repeat (12) @(posedge clock_i);
        host.pin(1'b0);
        repeat (90) @(posedge clock_i);
        check(12'(buck_a_on_o), 12'h0);
        $display("test delays done");
        conclude();
    end

    // About four times the expected run length
    initial begin
        repeat (3500) @(posedge clock_i);
        miscompares++;
        conclude();
    end
endmodule // test_regulator_control_regs
